// [hw/pwg_cmd_unit.v]
// pmbus write guard, default store commands and read-only bytes
// Notes on behaviour
// R1 - lock 80h: only lock command writable
// R2 - lock 40h: lock and operation writable
// R3 - lock 20h: lock, operation, on-off config writable
// R4 - lock 00h: every write accepted except to read-only bytes
// R5 - valid lock: at most one of 7:5, 4:0 zero
// R6 - invalid lock: flag fault, no protection
// R7 - store copies operating items into nvm
// R8 - after store force limits, vout, ceiling
// R9 - store/restore act on command alone
// R10 - restore overwrites operating items from nvm
// R11 - feature byte b0h, pec set, low zero
// R12 - bus speed field reads 01
// R13 - alert bit reads one
// R14 - vout format byte read-only, 21h default
// R15 - vout format write refused, data fault
// R16 - format mode 001, parameter per table
// R17 - refused write changes nothing
`timescale 1ns/1ns
module pwg_cmd_unit (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        rst_i,
    // command from the bus target front end
    input  wire        cmd_valid_i,
    input  wire        cmd_write_i,
    input  wire [7:0]  cmd_code_i,
    input  wire [15:0] cmd_data_i,
    // device configuration
    input  wire        newer_vid_table_i,
    input  wire [7:0]  boot_voltage_i,
    input  wire [15:0] max_current_setting_i,
    // fault flag clear from status logic
    input  wire        fault_clear_i,
    // answers
    output reg         done_o,
    output reg         accepted_o,
    output reg  [15:0] rdata_o,
    output reg         busy_o,
    // fault flags
    output reg         comm_fault_o,
    output reg         unsupported_data_flag_o,
    // operating settings
    output reg  [7:0]  write_lock_level_o,
    output reg  [15:0] vout_cmd_o,
    output reg  [15:0] vout_max_o,
    output reg  [15:0] oc_fault_o,
    output reg  [15:0] oc_warn_o
);
`include "pwg_consts.vh"

    // ---------------------------------------------------------------
    // operating memory and default store
    // ---------------------------------------------------------------
    // operating items live in op_mem, index given by map_idx
    reg  [15:0] op_mem  [0:`PWG_NVM_ITEMS-1];
    reg  [15:0] nvm_mem [0:`PWG_NVM_ITEMS-1];
    reg  [1:0]  state;
    reg  [`PWG_IDX_W-1:0] idx;

    // slot map: 0 operation, 1 on-off config, 2 vout command,
    // 3 vout ceiling, 4 overcurrent fault, 5 overcurrent warning;
    // codes outside the map, bar lock, store, restore, feature and format, read as zero and write nowhere
    // returns item index; bit 3 set means no backing item
    function [3:0] map_idx;
        input [7:0] code;
        begin
            case (code)
                `PWG_CMD_OPERATION:     map_idx = 4'h0;
                `PWG_CMD_ON_OFF_CONFIG: map_idx = 4'h1;
                `PWG_CMD_VOUT_COMMAND:  map_idx = 4'h2;
                `PWG_CMD_VOUT_MAX:      map_idx = 4'h3;
                `PWG_CMD_OC_FAULT:      map_idx = 4'h4;
                `PWG_CMD_OC_WARN:       map_idx = 4'h5;
                default:                map_idx = 4'h8;
            endcase
        end
    endfunction

    // item slots 6 and 7 hold no mapped item in either memory and are skipped
    function has_op;
        input [`PWG_IDX_W-1:0] i;
        begin
            has_op = (i < 3'h6);
        end
    endfunction

    // ---------------------------------------------------------------
    // lock decode
    // ---------------------------------------------------------------
    wire lock_allow;

    // validity is judged on the write below, where bits 4:0 still show
    pwg_lock_check u_lock (
        .lock_i       (write_lock_level_o),
        .cmd_i        (cmd_code_i),
        .lock_valid_o (),
        .allow_o      (lock_allow)
    );

    wire [3:0]  cmd_slot  = map_idx(cmd_code_i);
    wire        take      = cmd_valid_i && (state == `PWG_ST_IDLE);
    wire [15:0] oc_fault_def;
    // 125 percent of max current, as max plus a quarter
    // the sum wraps for settings above cccch
    assign oc_fault_def = max_current_setting_i +
                          {2'h0, max_current_setting_i[15:2]}; // [R8]

    wire [7:0] feature_byte = {1'b1,                    // [R11]
                               `PWG_SPD_400K,           // [R12]
                               1'b1,                    // [R13]
                               4'h0};                   // [R11]
    wire [4:0] vparam = newer_vid_table_i ? `PWG_VPARAM_NEWER
                                          : `PWG_VPARAM_OLDER;
    wire [7:0] vout_format = {`PWG_VMODE_VID, vparam};  // [R16]

    wire new_lock_bad = (cmd_data_i[7:0] != `PWG_LOCK_NONE) &&
                        (cmd_data_i[7:0] != `PWG_LOCK_ALL)  &&
                        (cmd_data_i[7:0] != `PWG_LOCK_OP)   &&
                        (cmd_data_i[7:0] != `PWG_LOCK_CFG);

    // ---------------------------------------------------------------
    // write admission
    // ---------------------------------------------------------------
    // an invalid lock byte opens the guard until the next lock write,
    // even where bits 7:5 alone look like a valid level (81h)
    reg  lock_void;
    wire guard_open = lock_allow || lock_void;                 // [R6]
    // read-only bytes never take a write, whatever the lock says
    wire ro_target  = (cmd_code_i == `PWG_CMD_VOUT_FORMAT) ||
                      (cmd_code_i == `PWG_CMD_FEATURE_RPT);    // [R14]
    wire refuse_wr  = !guard_open || ro_target;                // [R17]

    // ---------------------------------------------------------------
    // command engine
    // ---------------------------------------------------------------
    // store and restore walk all eight slots, one per cycle: busy
    // stands for eight cycles and done follows on the ninth edge;
    // requests that arrive meanwhile are dropped, not queued
    integer k;
    reg     set_fault;

    always @* begin
        set_fault = 1'b0;
        if (take && cmd_write_i) begin
            if (cmd_code_i == `PWG_CMD_VOUT_FORMAT)
                set_fault = 1'b1;                        // [R15]
            else if (cmd_code_i == `PWG_CMD_WRITE_LOCK && new_lock_bad)
                set_fault = 1'b1;                        // [R5] [R6]
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            state                   <= `PWG_ST_IDLE;
            idx                     <= 3'h0;
            done_o                  <= 1'b0;
            accepted_o              <= 1'b0;
            rdata_o                 <= 16'h0000;
            busy_o                  <= 1'b0;
            comm_fault_o            <= 1'b0;
            unsupported_data_flag_o <= 1'b0;
            write_lock_level_o      <= `PWG_LOCK_RESET;
            lock_void               <= 1'b0;
            vout_cmd_o              <= 16'h0000;
            vout_max_o              <= `PWG_VOUT_MAX_RESET;
            oc_fault_o              <= 16'h0000;
            oc_warn_o               <= 16'h0000;
            for (k = 0; k < `PWG_NVM_ITEMS; k = k + 1) begin
                op_mem[k]  <= 16'h0000;
                nvm_mem[k] <= 16'h0000;
            end
        end else begin
            done_o     <= 1'b0;
            accepted_o <= 1'b0;
            // set wins over clear: a fault that meets a clear is kept
            if (set_fault) begin
                comm_fault_o            <= 1'b1;         // [R6]
                unsupported_data_flag_o <= 1'b1;         // [R6]
            end else if (fault_clear_i) begin
                comm_fault_o            <= 1'b0;
                unsupported_data_flag_o <= 1'b0;
            end
            case (state)
                `PWG_ST_IDLE: begin
                    if (take) begin
                        if (!cmd_write_i) begin
                            // rdata holds until the next read
                            done_o     <= 1'b1;
                            accepted_o <= 1'b1;
                            case (cmd_code_i)
                                `PWG_CMD_FEATURE_RPT:
                                    rdata_o <= {8'h00, feature_byte};
                                `PWG_CMD_VOUT_FORMAT:
                                    rdata_o <= {8'h00, vout_format};
                                `PWG_CMD_WRITE_LOCK:
                                    rdata_o <= {8'h00, write_lock_level_o};
                                default:
                                    if (!cmd_slot[3])
                                        rdata_o <= op_mem[cmd_slot[2:0]];
                                    else
                                        rdata_o <= 16'h0000;
                            endcase
                        end else if (refuse_wr) begin
                            // refused: no setting touched; a format write still sets the fault flags
                            done_o <= 1'b1;                      // [R17] [R14]
                        end else if (cmd_code_i == `PWG_CMD_WRITE_LOCK) begin
                            done_o     <= 1'b1;
                            accepted_o <= 1'b1;
                            // keep 7:5 as written, zero 4:0; a bad 7:5 pattern reads back
                            write_lock_level_o <= {cmd_data_i[7:5], 5'h00};
                            // bad value leaves protection off [R6]
                            lock_void          <= new_lock_bad;
                        end else if (cmd_code_i == `PWG_CMD_STORE_ALL) begin
                            state  <= `PWG_ST_STORE;             // [R9]
                            idx    <= 3'h0;
                            busy_o <= 1'b1;
                        end else if (cmd_code_i == `PWG_CMD_RESTORE_ALL) begin
                            state  <= `PWG_ST_RESTORE;           // [R9]
                            idx    <= 3'h0;
                            busy_o <= 1'b1;
                        end else begin
                            done_o     <= 1'b1;
                            accepted_o <= 1'b1;
                            if (!cmd_slot[3])
                                op_mem[cmd_slot[2:0]] <= cmd_data_i;
                            if (cmd_code_i == `PWG_CMD_VOUT_COMMAND)
                                vout_cmd_o <= cmd_data_i;
                            if (cmd_code_i == `PWG_CMD_VOUT_MAX)
                                vout_max_o <= cmd_data_i;
                            if (cmd_code_i == `PWG_CMD_OC_FAULT)
                                oc_fault_o <= cmd_data_i;
                            if (cmd_code_i == `PWG_CMD_OC_WARN)
                                oc_warn_o <= cmd_data_i;
                        end
                    end
                end
                `PWG_ST_STORE: begin
                    // one item per cycle keeps a single store write port
                    if (has_op(idx))
                        nvm_mem[idx] <= op_mem[idx];             // [R7]
                    idx <= idx + 3'h1;
                    if (idx == 3'h7) begin
                        state      <= `PWG_ST_IDLE;
                        busy_o     <= 1'b0;
                        done_o     <= 1'b1;
                        accepted_o <= 1'b1;
                        oc_fault_o <= oc_fault_def;              // [R8]
                        oc_warn_o  <= max_current_setting_i;     // [R8]
                        vout_cmd_o <= {8'h00, boot_voltage_i};   // [R8]
                        vout_max_o <= `PWG_VOUT_MAX_RESET;       // [R8]
                        op_mem[4]  <= oc_fault_def;
                        op_mem[5]  <= max_current_setting_i;
                        op_mem[2]  <= {8'h00, boot_voltage_i};
                        op_mem[3]  <= `PWG_VOUT_MAX_RESET;
                    end
                end
                `PWG_ST_RESTORE: begin
                    // limits are not forced again: the store holds what
                    // the host saved, and a restore gives that back
                    if (has_op(idx)) begin
                        op_mem[idx] <= nvm_mem[idx];             // [R10]
                        if (idx == 3'h2)
                            vout_cmd_o <= nvm_mem[idx];
                        if (idx == 3'h3)
                            vout_max_o <= nvm_mem[idx];
                        if (idx == 3'h4)
                            oc_fault_o <= nvm_mem[idx];
                        if (idx == 3'h5)
                            oc_warn_o <= nvm_mem[idx];
                    end
                    idx <= idx + 3'h1;
                    if (idx == 3'h7) begin
                        state      <= `PWG_ST_IDLE;
                        busy_o     <= 1'b0;
                        done_o     <= 1'b1;
                        accepted_o <= 1'b1;
                    end
                end
                default: begin
                    state  <= `PWG_ST_IDLE;
                    busy_o <= 1'b0;
                end
            endcase
        end
    end

endmodule // pwg_cmd_unit

// [hw/pwg_consts.vh]
// constants for the pmbus write guard and default-store command block
`ifndef PWG_CONSTS_VH
`define PWG_CONSTS_VH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define PWG_CMD_OPERATION     8'h01
`define PWG_CMD_ON_OFF_CONFIG 8'h02
`define PWG_CMD_WRITE_LOCK    8'h10
`define PWG_CMD_STORE_ALL     8'h11
`define PWG_CMD_RESTORE_ALL   8'h12
`define PWG_CMD_FEATURE_RPT   8'h19
`define PWG_CMD_VOUT_FORMAT   8'h20
`define PWG_CMD_VOUT_COMMAND  8'h21
`define PWG_CMD_VOUT_MAX      8'h24
`define PWG_CMD_OC_FAULT      8'h46
`define PWG_CMD_OC_WARN       8'h4a

// ---------------------------------------------------------------
// write lock byte
// ---------------------------------------------------------------
`define PWG_LOCK_ALL          8'h80
`define PWG_LOCK_OP           8'h40
`define PWG_LOCK_CFG          8'h20
`define PWG_LOCK_NONE         8'h00
`define PWG_LOCK_RESET        8'h00

// ---------------------------------------------------------------
// read-only bytes and vout ceiling reset value
// ---------------------------------------------------------------
`define PWG_FEATURE_RESET     8'hb0
`define PWG_PEC_BIT           7
`define PWG_SPD_HI            6
`define PWG_SPD_LO            5
`define PWG_SPD_400K          2'h1
`define PWG_ALERT_BIT         4
`define PWG_VMODE_VID         3'h1
`define PWG_VPARAM_NEWER      5'h02
`define PWG_VPARAM_OLDER      5'h01
`define PWG_VOUT_MAX_RESET    16'h00ff

// ---------------------------------------------------------------
// memory geometry and internal state
// ---------------------------------------------------------------
`define PWG_NVM_ITEMS         8
`define PWG_IDX_W             3
`define PWG_ST_IDLE           2'h0
`define PWG_ST_STORE          2'h1
`define PWG_ST_RESTORE        2'h2

`endif

// [hw/pwg_lock_check.v]
// write lock decode: does the lock byte let a write to a command through
`timescale 1ns/1ns
module pwg_lock_check (
    // lock state and command
    input  wire [7:0] lock_i,
    input  wire [7:0] cmd_i,
    // decision
    output wire       lock_valid_o,
    output wire       allow_o
);
`include "pwg_consts.vh"

    // at most one of 7:5 set, 4:0 zero
    assign lock_valid_o = (lock_i == `PWG_LOCK_NONE) || // [R5]
                          (lock_i == `PWG_LOCK_ALL)  ||
                          (lock_i == `PWG_LOCK_OP)   ||
                          (lock_i == `PWG_LOCK_CFG);

    // invalid lock value means no protection
    assign allow_o =
        (!lock_valid_o) ||                                   // [R6]
        (lock_i == `PWG_LOCK_NONE) ||                        // [R4]
        (cmd_i == `PWG_CMD_WRITE_LOCK) ||                    // [R1]
        ((lock_i != `PWG_LOCK_ALL) &&
         (cmd_i == `PWG_CMD_OPERATION)) ||                   // [R2]
        ((lock_i == `PWG_LOCK_CFG) &&
         (cmd_i == `PWG_CMD_ON_OFF_CONFIG));                 // [R3]

endmodule // pwg_lock_check

// [tb/pwg_cmd_unit_properties.sv]
// concurrent checks on the ports of the write guard command unit
`timescale 1ns/1ns
module pwg_cmd_unit_checker (
    // clock and requests
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        cmd_valid_i,
    input wire logic        cmd_write_i,
    input wire logic [7:0]  cmd_code_i,
    input wire logic [15:0] cmd_data_i,
    input wire logic        newer_vid_table_i,
    input wire logic [7:0]  boot_voltage_i,
    input wire logic [15:0] max_current_setting_i,
    // answers and settings
    input wire logic        done_o,
    input wire logic        accepted_o,
    input wire logic [15:0] rdata_o,
    input wire logic        busy_o,
    input wire logic        comm_fault_o,
    input wire logic        unsupported_data_flag_o,
    input wire logic [7:0]  write_lock_level_o,
    input wire logic [15:0] vout_cmd_o,
    input wire logic [15:0] vout_max_o,
    input wire logic [15:0] oc_fault_o,
    input wire logic [15:0] oc_warn_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire       take = cmd_valid_i && !busy_o;
    wire       rd   = take && !cmd_write_i;
    wire       wr   = take && cmd_write_i;
    wire [7:0] lk   = write_lock_level_o;
    wire [7:0] c    = cmd_code_i;
    // an invalid lock write leaves the guard open whatever lk reads
    logic      lk_void;
    always @(posedge ref_clk_i)
        if (rst_i)
            lk_void <= 1'b0;
        else if (wr && c == 8'h10)
            lk_void <= !(cmd_data_i[7:0] inside {8'h00, 8'h80, 8'h40,
                                                 8'h20});

    property p_feat_read;
        rd && c == 8'h19 |=> done_o && rdata_o == 16'h00b0;
    endproperty
    a_feat_read: assert property (p_feat_read)
        else $error("feature byte read wrong");
    property p_fmt_read;
        rd && c == 8'h20 |=> done_o && rdata_o ==
            {8'h00, 3'h1, $past(newer_vid_table_i) ? 5'h02 : 5'h01};
    endproperty
    a_fmt_read: assert property (p_fmt_read)
        else $error("format byte read wrong");
    property p_fmt_wr;
        wr && c == 8'h20 |=> done_o && !accepted_o && comm_fault_o
            && unsupported_data_flag_o;
    endproperty
    a_fmt_wr: assert property (p_fmt_wr)
        else $error("format byte write not refused");
    property p_lock_all;
        wr && lk == 8'h80 && !lk_void && c != 8'h10
            |=> done_o && !accepted_o;
    endproperty
    a_lock_all: assert property (p_lock_all)
        else $error("write passed full lock");
    property p_lock_op;
        wr && lk == 8'h40 && !lk_void && !(c inside {8'h10, 8'h01})
            |=> !accepted_o;
    endproperty
    a_lock_op: assert property (p_lock_op)
        else $error("write passed operation lock");
    property p_lock_cfg;
        wr && lk == 8'h20 && !lk_void && !(c inside {8'h10, 8'h01, 8'h02})
            |=> !accepted_o;
    endproperty
    a_lock_cfg: assert property (p_lock_cfg)
        else $error("write passed config lock");
    property p_open;
        wr && (lk_void || !(lk inside {8'h80, 8'h40, 8'h20})) && (c inside
            {8'h01, 8'h02, 8'h21, 8'h24, 8'h46, 8'h4a})
            |=> done_o && accepted_o;
    endproperty
    a_open: assert property (p_open)
        else $error("write refused without lock");
    property p_bad_lock;
        wr && c == 8'h10 && !(cmd_data_i[7:0] inside {8'h00, 8'h80,
            8'h40, 8'h20}) |=> comm_fault_o && unsupported_data_flag_o;
    endproperty
    a_bad_lock: assert property (p_bad_lock)
        else $error("invalid lock not flagged");
    property p_store;
        wr && c == 8'h11 && (lk_void || !(lk inside {8'h80, 8'h40, 8'h20}))
            |=> busy_o[*8] ##1 (!busy_o && done_o
            && oc_fault_o == max_current_setting_i
               + (max_current_setting_i >> 2)
            && oc_warn_o == max_current_setting_i
            && vout_cmd_o == {8'h00, boot_voltage_i}
            && vout_max_o == 16'h00ff);
    endproperty
    a_store: assert property (p_store)
        else $error("store sequence or forced values wrong");
    property p_refused;
        done_o && !accepted_o |-> $stable(lk) && $stable(vout_cmd_o);
    endproperty
    a_refused: assert property (p_refused)
        else $error("refused write changed a setting");

    c_store:   cover property (wr && c == 8'h11);
    c_restore: cover property (wr && c == 8'h12);
    c_refuse:  cover property (done_o && !accepted_o);
    c_badlock: cover property (comm_fault_o);
endmodule // pwg_cmd_unit_checker

bind pwg_cmd_unit pwg_cmd_unit_checker u_pwg_cmd_unit_checker (.*);

// [tb/pwg_host_model.sv]
// bus host model: issues one command at a time and waits for its answer
`timescale 1ns/1ns
module pwg_host_model (
    // clock and answers
    input  wire logic        clk_i,
    input  wire logic        done_i,
    input  wire logic        accepted_i,
    input  wire logic [15:0] rdata_i,
    // request
    output logic             cmd_valid_o,
    output logic             cmd_write_o,
    output logic [7:0]       cmd_code_o,
    output logic [15:0]      cmd_data_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o  = 8'h00;
        cmd_data_o  = 16'h0000;
    end

    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [15:0] d, output logic a,
                        output logic [15:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_write_o = w;
        cmd_code_o  = c;
        // send-byte commands carry no data bytes
        cmd_data_o  = (c == 8'h11 || c == 8'h12) ? ~cmd_data_o : d;
        @(posedge clk_i);
        #1;
        cmd_valid_o = 1'b0;
        // released code and data lines keep no stale value
        cmd_code_o  = ~cmd_code_o;
        cmd_data_o  = ~cmd_data_o;
        while (done_i !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (done_i === 1'b1) begin
            a = accepted_i;
            r = rdata_i;
        end else begin
            // no answer in time: unknowns make the bench count it
            a = 1'bx;
            r = 16'hxxxx;
        end
    endtask
endmodule // pwg_host_model

// [tb/tb_pwg_cmd_unit.sv]
// testbench for the write guard and default-store command unit
`timescale 1ns/1ns
module tb_pwg_cmd_unit;
    typedef struct packed {
        logic wr; logic nv; logic [7:0] code; logic [15:0] data;
        logic acc; logic [15:0] rd;
    } pwg_row_t;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, fault_clear_i = 1'b0;
    logic newer_vid_table_i = 1'b1;
    logic [7:0] boot_voltage_i = 8'h5a;
    logic [15:0] max_current_setting_i = 16'h0100;
    wire cmd_valid, cmd_write, done, accepted, busy, cfault, udf;
    wire [7:0] cmd_code, lock;
    wire [15:0] cmd_data, rdata, vout_cmd, vout_max, oc_fault, oc_warn;
    int err_count = 0, checks_done = 0;
    logic acc;
    logic [15:0] rd;
    pwg_row_t rows [0:15] = '{
        '{0,1,8'h19,16'h0,1,16'h00b0}, '{0,1,8'h20,16'h0,1,16'h0022},
        '{0,0,8'h20,16'h0,1,16'h0021}, '{1,1,8'h21,16'h55,1,16'h0},
        '{1,1,8'h10,16'h80,1,16'h0}, '{1,1,8'h01,16'h1,0,16'h0},
        '{1,1,8'h10,16'h40,1,16'h0}, '{1,1,8'h01,16'h1,1,16'h0},
        '{1,1,8'h02,16'h1,0,16'h0}, '{1,1,8'h10,16'h20,1,16'h0},
        '{1,1,8'h02,16'h1,1,16'h0}, '{1,1,8'h21,16'h66,0,16'h0},
        '{1,1,8'h10,16'h00,1,16'h0}, '{1,1,8'h46,16'h9,1,16'h0},
        '{1,1,8'h19,16'h1,0,16'h0}, '{1,1,8'h20,16'h1,0,16'h0}};

    pwg_cmd_unit u_pwg_cmd_unit (.ref_clk_i, .rst_i,
        .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
        .cmd_code_i(cmd_code), .cmd_data_i(cmd_data), .newer_vid_table_i,
        .boot_voltage_i, .max_current_setting_i, .fault_clear_i,
        .done_o(done), .accepted_o(accepted), .rdata_o(rdata),
        .busy_o(busy), .comm_fault_o(cfault),
        .unsupported_data_flag_o(udf), .write_lock_level_o(lock),
        .vout_cmd_o(vout_cmd), .vout_max_o(vout_max),
        .oc_fault_o(oc_fault), .oc_warn_o(oc_warn));
    pwg_host_model u_pwg_host_model (.clk_i(ref_clk_i), .done_i(done),
        .accepted_i(accepted), .rdata_i(rdata), .cmd_valid_o(cmd_valid),
        .cmd_write_o(cmd_write), .cmd_code_o(cmd_code),
        .cmd_data_o(cmd_data));

    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    task cmp(input string name, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask
    task close_out;
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task go(input logic w, input logic [7:0] c, input logic [15:0] d);
        u_pwg_host_model.xfer(w, c, d, acc, rd);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        cmp("lock", 16'h0000, {8'h00, lock});
        foreach (rows[i]) begin
            newer_vid_table_i = rows[i].nv;
            go(rows[i].wr, rows[i].code, rows[i].data);
            if (rows[i].wr)
                cmp("accepted", {15'h0, rows[i].acc}, {15'h0, acc});
            else
                cmp("rdata", rows[i].rd, rd);
        end
        cmp("vout_cmd", 16'h0055, vout_cmd);
        cmp("flags", 16'h0003, {14'h0, cfault, udf});
        fault_clear_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        fault_clear_i = 1'b0;
        cmp("flags", 16'h0000, {14'h0, cfault, udf});
        go(1'b1, 8'h10, 16'h00c0);
        cmp("flags", 16'h0003, {14'h0, cfault, udf});
        go(1'b1, 8'h24, 16'h0044);
        cmp("accepted", 16'h0001, {15'h0, acc});
        go(1'b1, 8'h10, 16'h0081);
        cmp("lock", 16'h0080, {8'h00, lock});
        go(1'b1, 8'h01, 16'h0001);
        cmp("accepted", 16'h0001, {15'h0, acc});
        go(1'b1, 8'h10, 16'h0000);
        go(1'b1, 8'h21, 16'h0033);
        go(1'b1, 8'h11, 16'h0000);
        cmp("accepted", 16'h0001, {15'h0, acc});
        cmp("oc_fault", 16'h0140, oc_fault);
        cmp("oc_warn", 16'h0100, oc_warn);
        cmp("vout_cmd", 16'h005a, vout_cmd);
        cmp("vout_max", 16'h00ff, vout_max);
        go(1'b1, 8'h21, 16'h0077);
        go(1'b1, 8'h24, 16'h0011);
        go(1'b1, 8'h12, 16'h0000);
        cmp("vout_cmd", 16'h0033, vout_cmd);
        cmp("vout_max", 16'h0044, vout_max);
        // reset in mid-run must drop a live lock
        go(1'b1, 8'h10, 16'h0080);
        rst_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        cmp("lock", 16'h0000, {8'h00, lock});
        cmp("vout_max", 16'h00ff, vout_max);
        go(1'b1, 8'h46, 16'h0001);
        cmp("accepted", 16'h0001, {15'h0, acc});
        close_out();
    end

    initial begin
        #20000;
        err_count++;
        close_out();
    end
endmodule // tb_pwg_cmd_unit
